// File: verilog/cca_pkg.sv
// Constants, opcodes and states for the condition-code and addressing core
//Operation
//- Flag register is eight bits; bits 6 and 5 always read one.
//- Bit 7 flags two's complement overflow; signed branches test it.
//- Bit 4 flags carry from bit 3 into bit 4 on add and add-with-carry.
//- Decimal adjust corrects previous add result using half-carry and carry.
//- Bit 3 masks interrupts when one, accepts them when zero.
//- Taking an interrupt sets the mask after pushing, before the handler runs.
//- No interrupt at the boundary right after clearing a set mask.
//- Bit 2 copies the result's top bit; loads set it too.
//- Bit 1 set for zero 8-bit or 16-bit results and loads.
//- Bit 0 is carry out of bit 7 on add, borrow on subtract.
//- Shifts and rotates set or clear carry by their own definition.
//- One linear 64-Kbyte space with 16-bit addresses for all accesses.
//- Branching instructions use relative addressing for the branch target.
//- Inherent instructions take operands from registers, no memory access.
//- Relative offset byte is sign-extended and added to the program counter.
//- Immediate operand follows opcode; 16-bit high byte first, then low.
`default_nettype none
package cca_pkg;
    localparam logic [4:0]  ADDR_FLAGS = 5'h00;
    localparam logic [4:0]  ADDR_ACC  = 5'h04;
    localparam logic [4:0]  ADDR_PC   = 5'h08;
    localparam logic [4:0]  ADDR_HX   = 5'h0c;
    localparam logic [4:0]  ADDR_CTRL = 5'h10;

    localparam int          BIT_V = 7;
    localparam int          BIT_H = 4;
    localparam int          BIT_I = 3;
    localparam int          BIT_N = 2;
    localparam int          BIT_Z = 1;
    localparam int          BIT_C = 0;
    localparam logic [7:0]  FLAGS_ONES = 8'h60;
    localparam logic [7:0]  FLAGS_RST  = 8'h68;
    localparam logic [15:0] PC_RST   = 16'h0000;
    localparam logic [15:0] SP_RST   = 16'h00ff;
    localparam logic [15:0] IRQ_VEC  = 16'hff00;
    localparam logic [2:0]  PUSH_LAST = 3'h4;

    localparam logic [7:0]  OP_ADD  = 8'hab;
    localparam logic [7:0]  OP_ADC  = 8'ha9;
    localparam logic [7:0]  OP_SUB  = 8'ha0;
    localparam logic [7:0]  OP_LDA  = 8'ha6;
    localparam logic [7:0]  OP_LDHX = 8'h45;
    localparam logic [7:0]  OP_DAA  = 8'h72;
    localparam logic [7:0]  OP_LSLA = 8'h48;
    localparam logic [7:0]  OP_RORA = 8'h46;
    localparam logic [7:0]  OP_CLI  = 8'h9a;
    localparam logic [7:0]  OP_SEI  = 8'h9b;
    localparam logic [7:0]  OP_TAP  = 8'h84;
    localparam logic [7:0]  OP_TPA  = 8'h85;
    localparam logic [7:0]  OP_BRA  = 8'h20;
    localparam logic [7:0]  OP_BCS  = 8'h25;
    localparam logic [7:0]  OP_BNE  = 8'h26;
    localparam logic [7:0]  OP_BEQ  = 8'h27;
    localparam logic [7:0]  OP_BGE  = 8'h90;
    localparam logic [7:0]  OP_BLT  = 8'h91;

    typedef enum logic [5:0] {
        S_FETCH = 6'h01,
        S_WAIT  = 6'h02,
        S_TAKE  = 6'h04,
        S_EXEC  = 6'h08,
        S_PUSH  = 6'h10,
        S_VECT  = 6'h20
    } cca_state_e;
endpackage
`default_nettype wire

// File: verilog/cca_core.sv
// Condition-code logic and inherent, relative, immediate operand fetch
`default_nettype none
module cca_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        irq_req,
    output logic             irq_mask
);
    cca_pkg::cca_state_e state_reg;
    logic [15:0] pc_reg;
    logic [15:0] sp_reg;
    logic [15:0] hx_reg;
    logic [7:0]  a_reg;
    logic [7:0]  flg_reg;
    logic [7:0]  opcode_reg;
    logic [15:0] op_reg;
    logic [2:0]  cnt_reg;
    logic [1:0]  need_reg;
    logic        inhibit_reg;
    logic        run_reg;
    logic [15:0] mem_addr_reg;
    logic        mem_rd_reg;
    logic        mem_wr_reg;
    logic [7:0]  mem_wdata_reg;
    logic [15:0] rdata_reg;
    logic        irq_meta_reg;
    logic        irq_sync_reg;

    logic [7:0]  a_next;
    logic [15:0] hx_next;
    logic [7:0]  flg_next;
    logic        take;
    logic        clears_i;
    logic [8:0]  sum9;
    logic [4:0]  half5;
    logic [7:0]  res8;
    logic [7:0]  corr;
    logic        cin;
    logic [15:0] target;

    function automatic logic [1:0] opnd_count(input logic [7:0] opc);
        logic [1:0] n;
        n = 2'd0;
        case (opc)
            cca_pkg::OP_LDHX: n = 2'd2;
            cca_pkg::OP_ADD, cca_pkg::OP_ADC, cca_pkg::OP_SUB, cca_pkg::OP_LDA,
            cca_pkg::OP_BRA, cca_pkg::OP_BCS, cca_pkg::OP_BNE, cca_pkg::OP_BEQ,
            cca_pkg::OP_BGE, cca_pkg::OP_BLT: n = 2'd1;
            default: n = 2'd0;
        endcase
        return n;
    endfunction

    // Bits 6 and 5 forced on every store
    function automatic logic [7:0] flg_fix(input logic [7:0] v);
        return v | cca_pkg::FLAGS_ONES;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
        end else begin
            irq_meta_reg <= irq_req;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    assign target = pc_reg + {{8{op_reg[7]}}, op_reg[7:0]};

    always_comb begin
        a_next   = a_reg;
        hx_next  = hx_reg;
        flg_next = flg_reg;
        take     = 1'b0;
        clears_i = 1'b0;
        cin      = 1'b0;
        sum9     = 9'h000;
        half5    = 5'h00;
        res8     = a_reg;
        corr     = 8'h00;
        case (opcode_reg)
            cca_pkg::OP_ADD, cca_pkg::OP_ADC: begin
                cin   = (opcode_reg == cca_pkg::OP_ADC) & flg_reg[cca_pkg::BIT_C];
                sum9  = {1'b0, a_reg} + {1'b0, op_reg[7:0]} + {8'h00, cin};
                half5 = {1'b0, a_reg[3:0]} + {1'b0, op_reg[3:0]} + {4'h0, cin};
                res8  = sum9[7:0];
                a_next = res8;
                flg_next[cca_pkg::BIT_H] = half5[4];
                flg_next[cca_pkg::BIT_C] = sum9[8];
                flg_next[cca_pkg::BIT_V] = (a_reg[7] == op_reg[7]) && (res8[7] != a_reg[7]);
            end
            cca_pkg::OP_SUB: begin
                sum9  = {1'b0, a_reg} - {1'b0, op_reg[7:0]};
                res8  = sum9[7:0];
                a_next = res8;
                flg_next[cca_pkg::BIT_C] = sum9[8];
                flg_next[cca_pkg::BIT_V] = (a_reg[7] != op_reg[7]) && (res8[7] != a_reg[7]);
            end
            cca_pkg::OP_LDA: begin
                res8   = op_reg[7:0];
                a_next = res8;
                flg_next[cca_pkg::BIT_V] = 1'b0;
            end
            cca_pkg::OP_DAA: begin
                corr[3:0] = (flg_reg[cca_pkg::BIT_H] || a_reg[3:0] > 4'h9) ? 4'h6 : 4'h0;
                corr[7:4] = (flg_reg[cca_pkg::BIT_C] || a_reg > 8'h99) ? 4'h6 : 4'h0;
                res8   = a_reg + corr;
                a_next = res8;
                flg_next[cca_pkg::BIT_C] = flg_reg[cca_pkg::BIT_C] | (a_reg > 8'h99);
            end
            cca_pkg::OP_LSLA: begin
                res8   = {a_reg[6:0], 1'b0};
                a_next = res8;
                flg_next[cca_pkg::BIT_C] = a_reg[7];
                flg_next[cca_pkg::BIT_V] = a_reg[7] ^ a_reg[6];
            end
            cca_pkg::OP_RORA: begin
                res8   = {flg_reg[cca_pkg::BIT_C], a_reg[7:1]};
                a_next = res8;
                flg_next[cca_pkg::BIT_C] = a_reg[0];
                flg_next[cca_pkg::BIT_V] = a_reg[0] ^ flg_reg[cca_pkg::BIT_C];
            end
            cca_pkg::OP_CLI: begin
                flg_next[cca_pkg::BIT_I] = 1'b0;
                clears_i = flg_reg[cca_pkg::BIT_I];
            end
            cca_pkg::OP_SEI: flg_next[cca_pkg::BIT_I] = 1'b1;
            cca_pkg::OP_TAP: begin
                flg_next = a_reg;
                clears_i = flg_reg[cca_pkg::BIT_I] & ~a_reg[cca_pkg::BIT_I];
            end
            cca_pkg::OP_TPA: a_next = flg_fix(flg_reg);
            cca_pkg::OP_BRA: take = 1'b1;
            cca_pkg::OP_BCS: take = flg_reg[cca_pkg::BIT_C];
            cca_pkg::OP_BNE: take = ~flg_reg[cca_pkg::BIT_Z];
            cca_pkg::OP_BEQ: take = flg_reg[cca_pkg::BIT_Z];
            cca_pkg::OP_BGE: take = ~(flg_reg[cca_pkg::BIT_N] ^ flg_reg[cca_pkg::BIT_V]);
            cca_pkg::OP_BLT: take = flg_reg[cca_pkg::BIT_N] ^ flg_reg[cca_pkg::BIT_V];
            default: a_next = a_reg;
        endcase
        case (opcode_reg)
            cca_pkg::OP_ADD, cca_pkg::OP_ADC, cca_pkg::OP_SUB, cca_pkg::OP_LDA,
            cca_pkg::OP_DAA, cca_pkg::OP_LSLA, cca_pkg::OP_RORA: begin
                flg_next[cca_pkg::BIT_N] = res8[7];
                flg_next[cca_pkg::BIT_Z] = (res8 == 8'h00);
            end
            cca_pkg::OP_LDHX: begin
                hx_next = op_reg;
                flg_next[cca_pkg::BIT_N] = op_reg[15];
                flg_next[cca_pkg::BIT_Z] = (op_reg == 16'h0000);
                flg_next[cca_pkg::BIT_V] = 1'b0;
            end
            default: hx_next = hx_reg;
        endcase
    end

    // Sequencer: fetch, operand bytes, execute, interrupt entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg     <= cca_pkg::S_FETCH;
            pc_reg        <= cca_pkg::PC_RST;
            sp_reg        <= cca_pkg::SP_RST;
            hx_reg        <= 16'h0000;
            a_reg         <= 8'h00;
            opcode_reg    <= 8'h00;
            op_reg        <= 16'h0000;
            cnt_reg       <= 3'h0;
            need_reg      <= 2'd0;
            inhibit_reg   <= 1'b0;
            mem_addr_reg  <= 16'h0000;
            mem_rd_reg    <= 1'b0;
            mem_wr_reg    <= 1'b0;
            mem_wdata_reg <= 8'h00;
        end else begin
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            unique case (state_reg)
                cca_pkg::S_FETCH: begin
                    if (run_reg) begin
                        if (cnt_reg == 3'h0 && irq_sync_reg && !flg_reg[cca_pkg::BIT_I]
                            && !inhibit_reg) begin
                            state_reg <= cca_pkg::S_PUSH;
                        end else begin
                            mem_addr_reg <= pc_reg;
                            mem_rd_reg   <= 1'b1;
                            pc_reg       <= pc_reg + 16'h0001;
                            inhibit_reg  <= 1'b0;
                            state_reg    <= cca_pkg::S_WAIT;
                        end
                    end
                end
                cca_pkg::S_WAIT: state_reg <= cca_pkg::S_TAKE;
                cca_pkg::S_TAKE: begin
                    if (cnt_reg == 3'h0) begin
                        opcode_reg <= mem_rdata;
                        need_reg   <= opnd_count(mem_rdata);
                        if (opnd_count(mem_rdata) == 2'd0) begin
                            state_reg <= cca_pkg::S_EXEC;
                        end else begin
                            cnt_reg   <= 3'h1;
                            state_reg <= cca_pkg::S_FETCH;
                        end
                    end else begin
                        op_reg <= {op_reg[7:0], mem_rdata};
                        if (cnt_reg[1:0] == need_reg) begin
                            state_reg <= cca_pkg::S_EXEC;
                        end else begin
                            cnt_reg   <= cnt_reg + 3'h1;
                            state_reg <= cca_pkg::S_FETCH;
                        end
                    end
                end
                cca_pkg::S_EXEC: begin
                    a_reg       <= a_next;
                    hx_reg      <= hx_next;
                    inhibit_reg <= clears_i;
                    cnt_reg     <= 3'h0;
                    if (take) begin
                        pc_reg <= target;
                    end
                    state_reg <= cca_pkg::S_FETCH;
                end
                cca_pkg::S_PUSH: begin
                    mem_wr_reg   <= 1'b1;
                    mem_addr_reg <= sp_reg;
                    sp_reg       <= sp_reg - 16'h0001;
                    case (cnt_reg)
                        3'h0: mem_wdata_reg <= pc_reg[7:0];
                        3'h1: mem_wdata_reg <= pc_reg[15:8];
                        3'h2: mem_wdata_reg <= hx_reg[7:0];
                        3'h3: mem_wdata_reg <= a_reg;
                        default: mem_wdata_reg <= flg_fix(flg_reg);
                    endcase
                    if (cnt_reg == cca_pkg::PUSH_LAST) begin
                        cnt_reg   <= 3'h0;
                        state_reg <= cca_pkg::S_VECT;
                    end else begin
                        cnt_reg <= cnt_reg + 3'h1;
                    end
                end
                cca_pkg::S_VECT: begin
                    pc_reg    <= cca_pkg::IRQ_VEC;
                    state_reg <= cca_pkg::S_FETCH;
                end
            endcase
        end
    end

    // Flags: execution first, then interrupt entry, then software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flg_reg <= cca_pkg::FLAGS_RST;
        end else if (state_reg == cca_pkg::S_EXEC) begin
            flg_reg <= flg_fix(flg_next);
        end else if (state_reg == cca_pkg::S_VECT) begin
            flg_reg <= flg_fix(flg_reg | (8'h01 << cca_pkg::BIT_I));
        end else if (reg_wr && reg_addr == cca_pkg::ADDR_FLAGS) begin
            flg_reg <= flg_fix(reg_wdata[7:0]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_reg <= 1'b0;
        end else if (reg_wr && reg_addr == cca_pkg::ADDR_CTRL) begin
            run_reg <= reg_wdata[0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                cca_pkg::ADDR_FLAGS: rdata_reg <= {8'h00, flg_fix(flg_reg)};
                cca_pkg::ADDR_ACC:  rdata_reg <= {8'h00, a_reg};
                cca_pkg::ADDR_PC:   rdata_reg <= pc_reg;
                cca_pkg::ADDR_HX:   rdata_reg <= hx_reg;
                cca_pkg::ADDR_CTRL: rdata_reg <= {15'h0000, run_reg};
                default:            rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_reg;
    assign mem_addr  = mem_addr_reg;
    assign mem_rd    = mem_rd_reg;
    assign mem_wr    = mem_wr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign irq_mask  = flg_reg[cca_pkg::BIT_I];
endmodule
`default_nettype wire

// File: tb/cca_mem_model.sv
// Unified memory model answering the core one cycle after a read strobe
`default_nettype none
module cca_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    initial mem_rdata = 8'h00;
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            // Stale data is not held
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// File: tb/cca_core_monitor.sv
// Checker for flag read-back, memory strobes and interrupt entry
`default_nettype none
module cca_core_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata,
    input wire logic        irq_req,
    input wire logic        irq_mask
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence flag_read;
        $past(reg_rd) && $past(reg_addr) == cca_pkg::ADDR_FLAGS;
    endsequence
    sequence push_first;
        mem_wr && mem_addr == 16'h00ff;
    endsequence
    sequence push_last;
        mem_wr && mem_addr == 16'h00fb;
    endsequence
    a_ones_read: assert property (flag_read |-> reg_rdata[6:5] == 2'b11
        && reg_rdata[15:8] == 8'h00) else $error("flag read-back bits wrong");
    a_mask_read: assert property (flag_read and $stable(irq_mask)
        |-> reg_rdata[3] == irq_mask) else $error("mask bit differs from port");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_fetch_spacing: assert property (mem_rd |=> !mem_rd [*2])
        else $error("memory reads too close");
    a_strobes_apart: assert property (!(mem_rd && mem_wr))
        else $error("read and write together");
    a_push_unmasked: assert property (mem_wr |-> !irq_mask)
        else $error("stack push with mask set");
    a_push_order: assert property (push_first |-> ##[1:8] (mem_wr && mem_addr == 16'h00fe))
        else $error("second push missing");
    a_mask_after: assert property (push_last |-> ##[1:8] $rose(irq_mask))
        else $error("mask not set after pushes");
    a_vector_fetch: assert property (push_last |-> ##[1:10]
        (mem_rd && irq_mask && mem_addr == 16'hff00)) else $error("no fetch at vector");
endmodule
bind cca_core cca_core_monitor i_monitor (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_mask(irq_mask));
`default_nettype wire

// File: tb/cpu_condition_codes_and_addressing_test.sv
// Self-checking bench: random arithmetic, branches, immediates and interrupt entry
`default_nettype none
module cpu_condition_codes_and_addressing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_req = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_addr, seen;
    logic        mem_rd, mem_wr, irq_mask;
    logic [7:0]  mem_wdata, mem_rdata;
    logic [7:0]  prog [$];
    int          bad_count = 0, compares = 0, cycles = 0;
    always #5 clk = ~clk;
    cca_core i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .irq_req(irq_req), .irq_mask(irq_mask));
    cca_mem_model i_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 seen = reg_rdata;
    endtask
    task automatic run(input logic [7:0] flags);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        foreach (prog[i]) i_mem.mem[16'(i)] = prog[i];
        rst <= 1'b0;
        reg_write(cca_pkg::ADDR_FLAGS, {8'h00, flags});
        reg_write(cca_pkg::ADDR_CTRL, 16'h0001);
        repeat (80) @(posedge clk);
    endtask
    function automatic int nz(int f, int r);
        return (f & 8'hf9) | ((r & 8'h80) >> 5) | ((r == 0) ? 2 : 0);
    endfunction
    initial begin
        int a, b, op, cc, r, f, f0, m, c, v, h;
        static logic [7:0] opc [6] = '{8'hab, 8'ha9, 8'ha0, 8'hab, 8'h48, 8'h46};
        static logic [7:0] brc [6] = '{8'h20, 8'h25, 8'h26, 8'h27, 8'h90, 8'h91};
        void'($urandom(87240));
        i_mem.mem[16'hff00] = 8'h20;
        i_mem.mem[16'hff01] = 8'hfe;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_read(cca_pkg::ADDR_FLAGS);
        check(seen, 16'h0068);
        reg_read(5'h14);
        check(seen, 16'h0000);
        reg_write(cca_pkg::ADDR_FLAGS, 16'h0000);
        reg_read(cca_pkg::ADDR_FLAGS);
        check(seen, 16'h0060);
        check({15'h0000, irq_mask}, 16'h0000);
        for (int i = 0; i < 60; i++) begin
            op = i % 6;
            cc = ((op >= 4) && ((i / 6) % 6 >= 4)) ? 0 : (i / 6) % 6;
            a = $urandom_range(255);
            b = $urandom_range(255);
            if (op == 3) begin
                a = (($urandom_range(9)) << 4) | $urandom_range(9);
                b = (($urandom_range(9)) << 4) | $urandom_range(9);
            end
            f0 = 8'h68 | ($urandom_range(255) & 8'h97);
            f = nz(f0 & 8'h7f, a);
            m = 8'hff;
            r = a;
            prog = {8'ha6, 8'(a), opc[op]};
            if (op < 4) begin
                prog.push_back(8'(b));
                c = (op == 1) ? (f & 1) : 0;
                if (op == 2) begin
                    r = (a - b) & 255;
                    v = ((a ^ b) & (a ^ r) & 8'h80) ? 1 : 0;
                    f = nz((f & 8'h78) | (v << 7) | ((a < b) ? 1 : 0), r);
                end else begin
                    r = a + b + c;
                    h = ((a & 15) + (b & 15) + c) > 15;
                    v = (~(a ^ b) & (a ^ r) & 8'h80) ? 1 : 0;
                    f = nz((f & 8'h68) | (v << 7) | (h << 4) | (r >> 8), r & 255);
                    r = r & 255;
                end
            end else if (op == 4) begin
                r = (a << 1) & 255;
                f = nz((f & 8'h78) | (a >> 7), r);
                m = 8'h7f;
            end else begin
                r = (a >> 1) | ((f & 1) << 7);
                f = nz((f & 8'h78) | (a & 1), r);
                m = 8'h7f;
            end
            if (op == 3) begin
                prog.push_back(8'h72);
                c = f & 1;
                h = ((f & 8'h10) || (r & 15) > 9) ? 6 : 0;
                if (c || r > 8'h99) begin
                    h = h | 8'h60;
                    c = 1;
                end
                r = (r + h) & 255;
                f = nz((f & 8'hfe) | c, r);
                m = 8'hef;
            end
            case (cc)
                0: c = 1;
                1: c = f & 1;
                2: c = !(f & 2);
                3: c = (f & 2) != 0;
                4: c = ((f >> 2) & 1) == ((f >> 7) & 1);
                default: c = ((f >> 2) & 1) != ((f >> 7) & 1);
            endcase
            if (!c) begin
                r = 8'h11;
                f = f & 8'h79;
                m = 8'hff;
            end
            prog = {prog, brc[cc], 8'h02, 8'ha6, 8'h11, 8'h20, 8'hfe};
            run(8'(f0));
            reg_read(cca_pkg::ADDR_ACC);
            check(seen, 16'(r));
            reg_read(cca_pkg::ADDR_FLAGS);
            check(seen & 16'(m), 16'(f & m));
        end
        for (int j = 0; j < 2; j++) begin
            a = j ? (16'h8000 | $urandom_range(16'h7fff)) : 0;
            prog = {8'h45, 8'(a >> 8), 8'(a), 8'h20, 8'hfe};
            run(8'h68);
            reg_read(cca_pkg::ADDR_HX);
            check(seen, 16'(a));
            reg_read(cca_pkg::ADDR_FLAGS);
            check(seen, j ? 16'h006c : 16'h006a);
        end
        // Flag transfer both ways and mask set
        a = $urandom_range(255);
        prog = {8'ha6, 8'(a), 8'h84, 8'h9b, 8'h85, 8'h20, 8'hfe};
        run(8'h68);
        reg_read(cca_pkg::ADDR_ACC);
        check(seen, 16'(a | 8'h68));
        reg_read(cca_pkg::ADDR_FLAGS);
        check(seen, 16'(a | 8'h68));
        reg_read(cca_pkg::ADDR_CTRL);
        check(seen, 16'h0001);
        irq_req <= 1'b1;
        prog = {8'ha6, 8'h33, 8'h9a, 8'ha6, 8'h77, 8'h20, 8'hfe};
        run(8'h68);
        check({8'h00, i_mem.mem[16'h00ff]}, 16'h0005);
        check({8'h00, i_mem.mem[16'h00fe]}, 16'h0000);
        check({8'h00, i_mem.mem[16'h00fc]}, 16'h0077);
        check({8'h00, i_mem.mem[16'h00fb]}, 16'h0060);
        reg_read(cca_pkg::ADDR_FLAGS);
        check(seen, 16'h0068);
        irq_req <= 1'b0;
        close_out();
    end
endmodule
`default_nettype wire
